// ### bench/sixteen_bit_timer_counter_test.sv
// sixteen_bit_timer_counter_test: self-checking bench with count model
`timescale 1ns/100ps
module sixteen_bit_timer_counter_test;
    import stc_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic soft_reset = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = '0;
    logic hreadyout, hresp, osc_run, irq_req, wake_req, timebase_valid;
    logic [31:0] hrdata, rv;
    wire ext_count_input, osc_in_pin;
    logic sleep = 1'b0;
    logic [3:0] cmode = '0;
    logic special_trigger = 1'b0;
    stc_port_s port_c_in = 4'h3;
    stc_port_s port_c_out;
    logic [15:0] cv;
    int fails = 0;
    int n_tests = 0;
    int mdl;
    int mpsc = 0;
    bit mflag;

    stc_timer uut (.hclk(hclk), .hresetn(hresetn), .soft_reset(soft_reset),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ext_count_input(ext_count_input), .osc_in_pin(osc_in_pin),
        .sleep(sleep), .compare_unit_mode_field(cmode),
        .special_trigger(special_trigger), .port_c_in(port_c_in),
        .port_c_out(port_c_out), .osc_run(osc_run), .irq_req(irq_req),
        .wake_req(wake_req), .timebase_valid(timebase_valid));
    stc_pulse_src src (.ext_count_input(ext_count_input),
        .osc_in_pin(osc_in_pin));

    always #5 hclk = ~hclk;

    // --------------------------------------------------------
    // checking and bus tasks
    // --------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 100);
        if (hreadyout !== 1'b1) begin
            fails++;
            complete_run();
        end
    endtask

    task automatic xfer(input logic [9:0] idx, input logic w,
                        input logic [31:0] wd, input bit trg,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {idx, 2'b00};
        hwrite <= w;
        htrans <= 2'b10;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        special_trigger <= trg;
        wait_rdy();
        special_trigger <= 1'b0;
        rd = hrdata;
    endtask

    task automatic wr(input logic [9:0] i, input logic [31:0] d);
        xfer(i, 1'b1, d, 1'b0, rv);
    endtask

    task automatic rdchk(input string nm, input logic [9:0] i,
                         input logic [31:0] e);
        xfer(i, 1'b0, '0, 1'b0, rv);
        chk(nm, rv, e);
    endtask

    task automatic set_cnt(input int v);
        wr(STC_IDX_CNT_LO, 32'(v & 255));
        wr(STC_IDX_CNT_HI, 32'((v >> 8) & 255));
        mdl = v;
        mpsc = 0;
    endtask

    task automatic get_cnt(output logic [15:0] v);
        logic [31:0] h1, lo, h2;
        xfer(STC_IDX_CNT_HI, 1'b0, '0, 1'b0, h1);
        xfer(STC_IDX_CNT_LO, 1'b0, '0, 1'b0, lo);
        xfer(STC_IDX_CNT_HI, 1'b0, '0, 1'b0, h2);
        if (h1 !== h2) begin
            h1 = h2;
            xfer(STC_IDX_CNT_LO, 1'b0, '0, 1'b0, lo);
        end
        v = {h1[7:0], lo[7:0]};
    endtask

    task automatic cnt_chk(input string nm);
        get_cnt(cv);
        chk(nm, 32'(cv), 32'(mdl));
    endtask

    // ripple prescaler model: count when output bit ps-1 rises
    task automatic run_edges(input int k, input bit osc, input int ps);
        src.burst(k, osc, 50);
        repeat (12) @(posedge hclk);
        for (int j = 0; j < k; j++) begin
            mpsc = (mpsc + 1) & 7;
            if (mpsc % (1 << ps) == (1 << ps) / 2) begin
                mdl++;
            end
        end
        if (mdl > 65535) begin
            mdl = mdl - 65536;
            mflag = 1'b1;
        end
    endtask

    task automatic pulse_trig();
        @(posedge hclk);
        special_trigger <= 1'b1;
        @(posedge hclk);
        special_trigger <= 1'b0;
        @(posedge hclk);
    endtask

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        void'($urandom(32'h2ec8));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk("ctrl_rst", STC_IDX_CTRL, 32'h0);
        rdchk("flag_rst", STC_IDX_FLAG, 32'h0);
        wr(10'h040, 32'hffffffff);
        rdchk("unmapped", 10'h040, 32'h0);
        chk("hresp", 32'(hresp), 32'h0);
        wr(STC_IDX_CTRL, 32'hff);
        rdchk("ctrl_mask", STC_IDX_CTRL, 32'h3f);
        repeat (3) @(posedge hclk);
        chk("osc_on", 32'(osc_run), 32'h1);
        chk("pins_osc", 32'(port_c_out), 32'hc);
        wr(STC_IDX_CTRL, 32'h24);
        repeat (3) @(posedge hclk);
        chk("osc_off", 32'(osc_run), 32'h0);
        chk("pins_free", 32'(port_c_out), 32'h3);
        soft_reset <= 1'b1;
        @(posedge hclk);
        soft_reset <= 1'b0;
        @(posedge hclk);
        rdchk("ctrl_kept", STC_IDX_CTRL, 32'h24);
        wr(STC_IDX_CTRL, 32'h0);
        set_cnt($urandom_range(16'hffff, 0));
        repeat (40) @(posedge hclk);
        cnt_chk("hold");
        $display("test registers done");
        for (int c = 0; c < 4; c++) begin
            set_cnt(0);
            wr(STC_IDX_CTRL, 32'({c[1:0], 1'b0, 1'($urandom), 2'b01}));
            repeat (32 << c) @(posedge hclk);
            wr(STC_IDX_CTRL, 32'h0);
            get_cnt(cv);
            chk("tmr_rate", 32'(cv >= 7 && cv <= 9), 32'h1);
        end
        $display("test timer mode done");
        for (int i = 0; i < 16; i++) begin
            set_cnt($urandom_range(16'hff00, 0));
            wr(STC_IDX_CTRL, 32'({i[1:0], i[2], i[3], 2'b11}));
            repeat (20) @(posedge hclk);
            chk("tbase", 32'(timebase_valid), 32'(!i[3]));
            src.burst(5, !i[2], 50);
            run_edges($urandom_range(20, 4), i[2], i % 4);
            wr(STC_IDX_CTRL, 32'h0);
            cnt_chk("cnt_ext");
        end
        $display("test counter modes done");
        set_cnt(16'h0100);
        wr(STC_IDX_CTRL, 32'h03);
        sleep <= 1'b1;
        src.burst(6, 1'b0, 50);
        repeat (8) @(posedge hclk);
        sleep <= 1'b0;
        wr(STC_IDX_CTRL, 32'h0);
        cnt_chk("sleep_sync");
        wr(STC_IDX_IEN, 32'h1);
        wr(STC_IDX_FLAG, 32'h0);
        set_cnt(16'hfffe);
        mflag = 1'b0;
        wr(STC_IDX_CTRL, 32'h07);
        sleep <= 1'b1;
        run_edges(3, 1'b0, 0);
        chk("wake", 32'(wake_req), 32'h1);
        chk("irq_on", 32'(irq_req), 32'h1);
        sleep <= 1'b0;
        wr(STC_IDX_CTRL, 32'h0);
        cnt_chk("wrap");
        rdchk("flag_set", STC_IDX_FLAG, 32'(mflag));
        wr(STC_IDX_FLAG, 32'h0);
        repeat (3) @(posedge hclk);
        chk("irq_clr", 32'(irq_req), 32'h0);
        wr(STC_IDX_IEN, 32'h0);
        set_cnt(16'hfffe);
        wr(STC_IDX_CTRL, 32'h03);
        run_edges(3, 1'b0, 0);
        chk("irq_mask", 32'(irq_req), 32'h0);
        wr(STC_IDX_CTRL, 32'h0);
        rdchk("flag_mask", STC_IDX_FLAG, 32'h1);
        $display("test overflow done");
        wr(STC_IDX_FLAG, 32'h0);
        set_cnt($urandom_range(16'hfff0, 1));
        cmode <= STC_CMP_TRIG;
        pulse_trig();
        mdl = 0;
        cnt_chk("trig_clr");
        rdchk("trig_flag", STC_IDX_FLAG, 32'h0);
        set_cnt(16'h1234);
        cmode <= STC_CMP_TRIG ^ 4'($urandom_range(15, 1));
        pulse_trig();
        cnt_chk("trig_mode");
        cmode <= STC_CMP_TRIG;
        xfer(STC_IDX_CNT_LO, 1'b1, 32'h55, 1'b1, rv);
        mdl = 16'h1255;
        cnt_chk("trig_vs_wr");
        wr(STC_IDX_CTRL, 32'h33);
        set_cnt(0);
        run_edges(5, 1'b0, 3);
        wr(STC_IDX_CNT_LO, 32'h0);
        // a count write restarts the prescaler
        mdl = mdl & 32'hff00;
        mpsc = 0;
        run_edges(5, 1'b0, 3);
        wr(STC_IDX_CTRL, 32'h0);
        cnt_chk("ps_clr");
        $display("test trigger and prescaler clear done");
        complete_run();
    end
endmodule // sixteen_bit_timer_counter_test

// ### bench/stc_pulse_src.sv
// stc_pulse_src: external count pin and crystal pin source
`timescale 1ns/100ps
module stc_pulse_src (
    output logic ext_count_input, // count pin
    output logic osc_in_pin // crystal input pin
);
    // --------------------------------------------------------
    // edge bursts
    // --------------------------------------------------------
    initial begin
        ext_count_input = 1'b0;
        osc_in_pin = 1'b0;
    end

    // both pins rest low between bursts; high and low times
    // stay well above two instruction phases
    task automatic burst(input int k, input bit osc, input int half);
        // step off the clock edge so pin changes never race sampling
        #1;
        for (int i = 0; i < k; i++) begin
            if (osc) osc_in_pin = 1'b1;
            else ext_count_input = 1'b1;
            #(half);
            if (osc) osc_in_pin = 1'b0;
            else ext_count_input = 1'b0;
            #(half);
        end
    endtask
endmodule // stc_pulse_src

// ### hdl/stc_timer.sv
// stc_timer: sixteen-bit timer/counter with AHB-Lite register slave
// Summary of operation
// - count wraps from ffff to zero
// - wrap latches flag, interrupt only if enabled
// - source bit picks instruction clock or edges
// - oscillator enable picks oscillator or count pin
// - on bit runs or holds count
// - prescale codes divide by 1,2,4,8
// - control bits 7:6 read zero
// - sync bit ignored with internal clock
// - sync mode aligns prescaler output to phases
// - sync mode samples at Q2 and Q4
// - sync mode frozen in sleep, prescaler runs
// - async mode runs in sleep, wakes processor
// - async mode is no capture/compare time base
// - async reads of count bytes are valid
// - oscillator forces pins input, reads zero
// - oscillator runs when enabled, also in sleep
// - compare trigger mode clears the count
// - trigger clear never sets flag
// - trigger honoured only outside async mode
// - count write beats a trigger
// - count byte write clears prescaler
// - control clears on power-on only
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/100ps
module stc_timer (
    input wire logic hclk, // bus clock
    input wire logic hresetn, // power-on reset, active low
    input wire logic soft_reset, // other resets, leave control
    input wire logic hsel, // slave select
    input wire logic [11:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write strobe
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    input wire logic ext_count_input, // external count pin
    input wire logic osc_in_pin, // oscillator input pin
    input wire logic sleep, // processor in sleep
    input wire logic [3:0] compare_unit_mode_field, // compare mode
    input wire logic special_trigger, // compare trigger pulse
    input wire stc_pkg::stc_port_s port_c_in, // pin dirs and levels
    output stc_pkg::stc_port_s port_c_out, // effective dirs, reads
    output logic osc_run, // oscillator enable
    output logic irq_req, // overflow interrupt request
    output logic wake_req, // wake from sleep
    output logic timebase_valid // usable by capture/compare
);
    import stc_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [15:0] cnt_q;
    logic flag_q;
    logic ien_q;
    logic [2:0] psc_q;
    stc_phase_e phase_q;
    logic ext_s1_q, ext_s2_q, osc_s1_q, osc_s2_q;
    logic edge_prev_q;
    logic lvl_prev_q;
    logic smp_q;
    logic dph_q;
    logic dwr_q;
    logic [9:0] didx_q;
    stc_ctrl_s c;

    assign c = stc_ctrl_s'(ctrl_q[5:0]);
    function automatic logic [9:0] word_idx(input logic [11:0] a);
        word_idx = a[11:2];
    endfunction

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic take;
    logic wr_lo, wr_hi, wr_ctrl, wr_flag, wr_ien;
    assign take = hsel & hready & htrans[1];
    assign wr_lo = dph_q & dwr_q & (didx_q == STC_IDX_CNT_LO);
    assign wr_hi = dph_q & dwr_q & (didx_q == STC_IDX_CNT_HI);
    assign wr_ctrl = dph_q & dwr_q & (didx_q == STC_IDX_CTRL);
    assign wr_flag = dph_q & dwr_q & (didx_q == STC_IDX_FLAG);
    assign wr_ien = dph_q & dwr_q & (didx_q == STC_IDX_IEN);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_q <= 1'b0;
            dwr_q <= 1'b0;
            didx_q <= 10'h000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready) begin
                dph_q <= take;
                dwr_q <= take & hwrite;
                didx_q <= word_idx(haddr);
            end
        end
    end

    // read data captured in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (take & ~hwrite) begin
            case (word_idx(haddr))
                STC_IDX_CNT_LO: hrdata <= {24'h000000, cnt_q[7:0]};
                STC_IDX_CNT_HI: hrdata <= {24'h000000, cnt_q[15:8]};
                STC_IDX_CTRL: hrdata <= {24'h000000, ctrl_q & STC_CTRL_MASK};
                STC_IDX_FLAG: hrdata <= {31'h00000000, flag_q};
                STC_IDX_IEN: hrdata <= {31'h00000000, ien_q};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= STC_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= hwdata[7:0] & STC_CTRL_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ien_q <= 1'b0;
        end else if (soft_reset) begin
            ien_q <= 1'b0;
        end else if (wr_ien) begin
            ien_q <= hwdata[STC_B_FLAG];
        end
    end

    // ------------------------------------------------------------
    // phase clocks and pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q <= STC_Q1;
        end else begin
            case (phase_q)
                STC_Q1: phase_q <= STC_Q2;
                STC_Q2: phase_q <= STC_Q3;
                STC_Q3: phase_q <= STC_Q4;
                STC_Q4: phase_q <= STC_Q1;
                default: phase_q <= STC_Q1;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_count_input;
            ext_s2_q <= ext_s1_q;
            osc_s1_q <= osc_in_pin;
            osc_s2_q <= osc_s1_q;
        end
    end

    // ------------------------------------------------------------
    // source select and prescaler
    // ------------------------------------------------------------
    logic edge_src, src_rise, async_mode, sync_mode;
    logic [2:0] ps_mask;
    logic psc_lvl, psc_tick, inc, smp_rise;

    assign edge_src = c.osc_enable ? osc_s2_q : ext_s2_q;
    assign src_rise = c.clock_source_select ?
        (edge_src & ~edge_prev_q) : ((phase_q == STC_Q4) & ~sleep);
    assign async_mode = c.clock_source_select & c.sync_disable;
    assign sync_mode = c.clock_source_select & ~c.sync_disable;
    assign ps_mask = 3'((32'd1 << c.ps) - 32'd1);
    assign psc_tick = src_rise & ((psc_q & ps_mask) == ps_mask);
    assign psc_lvl = (c.ps == 2'b00) ? edge_src : psc_q[c.ps - 2'd1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            edge_prev_q <= 1'b0;
            lvl_prev_q <= 1'b0;
        end else begin
            edge_prev_q <= edge_src;
            lvl_prev_q <= psc_lvl;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            psc_q <= 3'h0;
        end else if (wr_lo | wr_hi | soft_reset) begin
            psc_q <= 3'h0;
        end else if (c.counter_on & src_rise) begin
            psc_q <= psc_q + 3'h1;
        end
    end

    // samples taken on Q2 and Q4
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            smp_q <= 1'b0;
        end else if (phase_q == STC_Q2 || phase_q == STC_Q4) begin
            smp_q <= psc_lvl;
        end
    end

    assign smp_rise = (phase_q == STC_Q2 || phase_q == STC_Q4) &
        psc_lvl & ~smp_q;

    // sync after prescaler, frozen in sleep, async runs
    always_comb begin
        if (!c.counter_on) begin
            inc = 1'b0;
        end else if (sync_mode) begin
            inc = smp_rise & ~sleep;
        end else if (async_mode) begin
            inc = psc_lvl & ~lvl_prev_q;
        end else begin
            inc = psc_tick;
        end
    end

    // ------------------------------------------------------------
    // count, trigger and overflow
    // ------------------------------------------------------------
    logic trig, wrap;

    // trigger mode clear, not in async mode
    assign trig = special_trigger & ~async_mode &
        (compare_unit_mode_field == STC_CMP_TRIG);
    // only a wrap sets the flag
    assign wrap = inc & (cnt_q == STC_CNT_MAX) & ~wr_lo & ~wr_hi & ~trig;

    // up-count with wrap, hold when off, write wins
    always_ff @(posedge hclk) begin
        if (wr_lo) begin
            cnt_q[7:0] <= hwdata[7:0];
        end else if (wr_hi) begin
            cnt_q[15:8] <= hwdata[7:0];
        end else if (trig) begin
            cnt_q <= 16'h0000;
        end else if (inc) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_q <= 1'b0;
        end else if (wrap) begin
            flag_q <= 1'b1;
        end else if (soft_reset) begin
            flag_q <= 1'b0;
        end else if (wr_flag & ~hwdata[STC_B_FLAG]) begin
            flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_req <= 1'b0;
            wake_req <= 1'b0;
            osc_run <= 1'b0;
            timebase_valid <= 1'b0;
            port_c_out <= '0;
        end else begin
            irq_req <= flag_q & ien_q;
            wake_req <= flag_q & ien_q & sleep & async_mode;
            osc_run <= c.osc_enable;
            timebase_valid <= ~async_mode;
            port_c_out.dir <= c.osc_enable ? 2'b11 : port_c_in.dir;
            port_c_out.rd <= c.osc_enable ? 2'b00 : port_c_in.rd;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_wrap_zero;
        @(posedge hclk) disable iff (!hresetn)
        wrap |=> (cnt_q == 16'h0000);
    endproperty
    a_wrap_zero: assert property (p_wrap_zero)
        else $error("count did not wrap to zero");
    property p_flag_irq;
        @(posedge hclk) disable iff (!hresetn)
        wrap ##1 ien_q |=> irq_req;
    endproperty
    a_flag_irq: assert property (p_flag_irq)
        else $error("enabled overflow gave no request");
    property p_no_irq_masked;
        @(posedge hclk) disable iff (!hresetn)
        !ien_q |=> !irq_req;
    endproperty
    a_no_irq_masked: assert property (p_no_irq_masked)
        else $error("request while disabled");
    property p_hold_off;
        @(posedge hclk) disable iff (!hresetn)
        !c.counter_on && !wr_lo && !wr_hi && !trig |=> $stable(cnt_q);
    endproperty
    a_hold_off: assert property (p_hold_off)
        else $error("count moved while stopped");
    property p_ctrl_top;
        @(posedge hclk) disable iff (!hresetn)
        ctrl_q[7:6] == 2'b00;
    endproperty
    a_ctrl_top: assert property (p_ctrl_top)
        else $error("unimplemented control bits set");
    property p_sleep_sync;
        @(posedge hclk) disable iff (!hresetn)
        sync_mode && sleep && !wr_lo && !wr_hi && !trig |=> $stable(cnt_q);
    endproperty
    a_sleep_sync: assert property (p_sleep_sync)
        else $error("sync counter moved in sleep");
    property p_trig_clear;
        @(posedge hclk) disable iff (!hresetn)
        trig && !wr_lo && !wr_hi |=> cnt_q == 16'h0000 && !$rose(flag_q);
    endproperty
    a_trig_clear: assert property (p_trig_clear)
        else $error("trigger clear wrong");
    property p_write_wins;
        @(posedge hclk) disable iff (!hresetn)
        wr_lo |=> cnt_q[7:0] == $past(hwdata[7:0]);
    endproperty
    a_write_wins: assert property (p_write_wins)
        else $error("count write lost");
    property p_psc_clear;
        @(posedge hclk) disable iff (!hresetn)
        wr_hi |=> psc_q == 3'h0;
    endproperty
    a_psc_clear: assert property (p_psc_clear)
        else $error("prescaler not cleared");
    property p_pins;
        @(posedge hclk) disable iff (!hresetn)
        c.osc_enable |=> port_c_out.dir == 2'b11 && port_c_out.rd == 2'b00;
    endproperty
    a_pins: assert property (p_pins)
        else $error("oscillator pins not forced");

endmodule // stc_timer

// ### inc/stc_pkg.sv
// stc_pkg: constants and types for the sixteen-bit timer/counter
package stc_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [9:0] STC_IDX_FLAG = 10'h00c;
    localparam logic [9:0] STC_IDX_IEN = 10'h08c;
    localparam logic [9:0] STC_IDX_CNT_LO = 10'h00e;
    localparam logic [9:0] STC_IDX_CNT_HI = 10'h00f;
    localparam logic [9:0] STC_IDX_CTRL = 10'h010;

    // ------------------------------------------------------------
    // timer_control field positions and reset value
    // ------------------------------------------------------------
    localparam int STC_B_ON = 0;
    localparam int STC_B_CS = 1;
    localparam int STC_B_SYNC = 2;
    localparam int STC_B_OSC = 3;
    localparam int STC_B_PS_LO = 4;
    localparam int STC_B_PS_HI = 5;
    localparam logic [7:0] STC_CTRL_RST = 8'h00;
    localparam logic [7:0] STC_CTRL_MASK = 8'h3f;
    localparam int STC_B_FLAG = 0;

    // ------------------------------------------------------------
    // compare unit and timing
    // ------------------------------------------------------------
    localparam logic [3:0] STC_CMP_TRIG = 4'hb;
    localparam logic [15:0] STC_CNT_MAX = 16'hffff;
    localparam int STC_PHASES = 4;

    // instruction-cycle phases, one-hot
    typedef enum logic [3:0] {
        STC_Q1 = 4'h1,
        STC_Q2 = 4'h2,
        STC_Q3 = 4'h4,
        STC_Q4 = 4'h8
    } stc_phase_e;

    // decoded control bits
    typedef struct packed {
        logic [1:0] ps;
        logic osc_enable;
        logic sync_disable;
        logic clock_source_select;
        logic counter_on;
    } stc_ctrl_s;

    // port pins shared with the oscillator
    typedef struct packed {
        logic [1:0] dir;
        logic [1:0] rd;
    } stc_port_s;

endpackage
